// >>> src/cafa_regs.svh
// Register offsets, flag bit positions and reset values
// Included by the flags and core files of the flags and addressing block
`ifndef CAFA_REGS_SVH
`define CAFA_REGS_SVH
// Register port offsets
`define CAFA_R_FLAGS 4'h0
`define CAFA_R_IXH 4'h1
`define CAFA_R_IXL 4'h2
`define CAFA_R_IYH 4'h3
`define CAFA_R_IYL 4'h4
`define CAFA_R_PCH 4'h5
`define CAFA_R_PCL 4'h6
`define CAFA_R_CTRL 4'h7
`define CAFA_R_EAH 4'h8
`define CAFA_R_EAL 4'h9
`define CAFA_R_OPC 4'hA
`define CAFA_R_INFO 4'hB
`define CAFA_R_RES 4'hC
// Control register field
`define CAFA_CTRL_RUN 0
// Flag bit positions
`define CAFA_F_S 7
`define CAFA_F_X 6
`define CAFA_F_H 5
`define CAFA_F_I 4
`define CAFA_F_N 3
`define CAFA_F_Z 2
// Flags after reset: stop disable, both masks set
`define CAFA_FLAGS_RST 8'hD0
`endif

// >>> src/cafa_pkg.sv
// Types shared by the flags and addressing block
// No dependencies
package cafa_pkg;
  typedef enum logic [2:0] {
    M_INH, M_IMM, M_DIR, M_EXT, M_IND, M_REL
  } cafa_mode_t;
  typedef enum logic [3:0] {
    K_NONE, K_ADD, K_ADC, K_SUMBA, K_SUB, K_CMP, K_AND, K_LOAD,
    K_XINC, K_XDEC, K_YINC, K_YDEC, K_TAP, K_RETI, K_CLI, K_STOP
  } cafa_op_t;
  typedef enum logic [2:0] {
    S_IDLE, S_REQ, S_TAKE, S_DONE, S_HALT
  } cafa_fsm_t;
endpackage

// >>> src/cafa_ea.sv
// Effective address former for all addressing modes
// Operands arrive already assembled, most significant byte first
module cafa_ea (
  // Decoded instruction
  input wire cafa_pkg::cafa_mode_t mode,
  input wire logic use_y,
  input wire logic [7:0] first,
  input wire logic [15:0] opnd,
  // Address sources
  input wire logic [15:0] xidx,
  input wire logic [15:0] yidx,
  input wire logic [15:0] imm_addr,
  input wire logic [15:0] next_pc,
  // Result
  output logic [15:0] ea,
  output logic ea_valid
);
  import cafa_pkg::*;

  // Address per mode
  always_comb begin
    ea = 16'h0000;
    ea_valid = 1'b1;
    case (mode)
      M_IMM: ea = imm_addr;
      M_DIR: ea = {8'h00, first};
      M_EXT: ea = opnd;
      M_IND: ea = (use_y ? yidx : xidx) + {8'h00, first};
      M_REL: ea = next_pc + {{8{opnd[7]}}, opnd[7:0]};
      default: ea_valid = 1'b0;
    endcase
  end
endmodule

// >>> src/cafa_flags.sv
// Condition flag register with interrupt mask handling
// Operations arrive as one-cycle pulses from the execution unit
`include "cafa_regs.svh"
module cafa_flags (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Operation
  input wire logic op_valid,
  input wire cafa_pkg::cafa_op_t op_kind,
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  input wire logic carry_in,
  input wire logic idx_zero,
  // Interrupts
  input wire logic irq_req,
  input wire logic hpri_req,
  input wire logic irq_stacked,
  input wire logic hpri_stacked,
  output logic irq_grant,
  output logic hpri_grant,
  // Results
  output logic [7:0] flags,
  output logic [7:0] result,
  output logic stop_halt
);
  import cafa_pkg::*;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] result;
  } cafa_flg_st_t;

  cafa_flg_st_t cur;
  cafa_flg_st_t next_st;
  logic cin;
  logic nz_upd;
  logic [4:0] low_sum;
  logic [7:0] res;

  // Arithmetic and next flags
  always_comb begin
    next_st = cur;
    cin = (op_kind == K_ADC) ? carry_in : 1'b0;
    low_sum = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cin};
    case (op_kind)
      K_ADD, K_ADC, K_SUMBA: res = op_a + op_b + {7'h00, cin};
      K_SUB, K_CMP: res = op_a - op_b;
      K_AND: res = op_a & op_b;
      default: res = op_a;
    endcase
    nz_upd = op_valid && (op_kind inside {K_ADD, K_ADC, K_SUMBA, K_SUB, K_CMP, K_AND, K_LOAD});
    if (nz_upd) begin
      next_st.flags[`CAFA_F_N] = res[7];
      next_st.flags[`CAFA_F_Z] = (res == 8'h00);
      if (op_kind != K_CMP) next_st.result = res;
    end
    if (op_valid) begin
      case (op_kind)
        K_ADD, K_ADC, K_SUMBA: next_st.flags[`CAFA_F_H] = low_sum[4];
        K_XINC, K_XDEC, K_YINC, K_YDEC: next_st.flags[`CAFA_F_Z] = idx_zero;
        K_TAP, K_RETI: begin
          next_st.flags = op_a;
          next_st.flags[`CAFA_F_X] = cur.flags[`CAFA_F_X] & op_a[`CAFA_F_X];
        end
        K_CLI: next_st.flags[`CAFA_F_I] = 1'b0;
        default: ;
      endcase
    end
    // Acknowledge after stacking wins over any clear
    if (irq_stacked) next_st.flags[`CAFA_F_I] = 1'b1;
    if (hpri_stacked) begin
      next_st.flags[`CAFA_F_X] = 1'b1;
      next_st.flags[`CAFA_F_I] = 1'b1;
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur <= '{flags: `CAFA_FLAGS_RST, result: 8'h00};
    end else begin
      cur <= next_st;
    end
  end

  // Outputs
  assign flags = cur.flags;
  assign result = cur.result;
  assign irq_grant = irq_req & ~cur.flags[`CAFA_F_I];
  assign hpri_grant = hpri_req & ~cur.flags[`CAFA_F_X];
  assign stop_halt = op_valid && op_kind == K_STOP && !cur.flags[`CAFA_F_S];

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_zero_result: assert property (nz_upd |=> flags[`CAFA_F_Z] == ($past(res) == 8'h00))
    else $error("zero flag mismatch");
  a_cmp_nostore: assert property (op_valid && op_kind == K_CMP |=> $stable(result))
    else $error("compare stored its difference");
  a_index_zonly: assert property (op_valid && op_kind inside {K_XINC, K_XDEC, K_YINC, K_YDEC}
    && !irq_stacked && !hpri_stacked |=> {flags[7:3], flags[1:0]} == $past({flags[7:3], flags[1:0]}))
    else $error("index step touched other flags");
  a_neg_msb: assert property (nz_upd |=> flags[`CAFA_F_N] == $past(res[7]))
    else $error("negative flag mismatch");
  a_irq_masked: assert property (flags[`CAFA_F_I] |-> !irq_grant)
    else $error("masked interrupt granted");
  a_i_sw_clear: assert property ($fell(flags[`CAFA_F_I]) |->
    $past(op_valid) && $past(op_kind) inside {K_TAP, K_RETI, K_CLI})
    else $error("mask cleared without instruction");
  a_half_carry: assert property (op_valid && op_kind inside {K_ADD, K_ADC, K_SUMBA}
    |=> flags[`CAFA_F_H] == $past(low_sum[4]))
    else $error("half carry mismatch");
  a_xack_sets: assert property (hpri_stacked |=> flags[`CAFA_F_X] && flags[`CAFA_F_I])
    else $error("high priority acknowledge did not mask");
  a_x_no_hw: assert property ($fell(flags[`CAFA_F_X]) |-> $past(op_valid)
    && $past(op_kind) inside {K_TAP, K_RETI})
    else $error("high priority mask cleared by hardware");
endmodule

// >>> src/cafa_core.sv
// Prebyte and opcode fetch, effective address and register port
// Memory answers a read with data in the cycle after mem_rd
//
// Decided for this implementation: the address-and-strobe port and the address map.
`include "cafa_regs.svh"

// Overview of operation
// - Zero flag set when result equals zero
// - Compare subtracts, updates flags, stores nothing
// - Index step changes only the zero flag
// - Negative flag copies result most significant bit
// - Global mask holds maskable requests pending
// - Reset sets global mask; software clears it
// - Interrupt acknowledge sets global mask after stacking
// - Half carry from bit 3 on adds
// - High priority mask set by reset, acknowledge
// - High priority mask cleared only by software
// - Halt with stop disable acts as no-operation
// - Words stored most significant byte first
// - Fetch at any byte address
// - Prebyte selects one of three other pages
// - Instruction is one to five bytes
// - Immediate operand width matches operated register
// - Direct address has high byte zero
// - Extended address is two following bytes
// - Inherent mode has no effective address
// - Indexed adds unsigned offset to index
// - Taken branch adds signed offset to counter
module cafa_core #(
  parameter logic [7:0] PRE_P1 = 8'h18,
  parameter logic [7:0] PRE_P2 = 8'h1A,
  parameter logic [7:0] PRE_P3 = 8'hCD
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Program and data memory
  output logic [15:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  // Decoded instruction
  output logic instr_done,
  output logic [1:0] instr_page,
  output logic [7:0] instr_opcode,
  output cafa_pkg::cafa_mode_t instr_mode,
  output logic [2:0] instr_len,
  output logic [23:0] instr_operand,
  output logic [15:0] instr_ea,
  output logic instr_ea_valid,
  input wire logic branch_true,
  // Execution unit operation
  input wire logic op_valid,
  input wire cafa_pkg::cafa_op_t op_kind,
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  input wire logic carry_in,
  output logic [7:0] alu_result,
  output logic [7:0] condition_flags_reg,
  // Interrupt handshake
  input wire logic irq_req,
  input wire logic high_priority_int_pin,
  input wire logic irq_stacked,
  input wire logic hpri_stacked,
  output logic irq_grant,
  output logic hpri_grant,
  output logic low_power
);
  import cafa_pkg::*;

  // Prebyte codes must be distinct
  if (PRE_P1 == PRE_P2 || PRE_P1 == PRE_P3 || PRE_P2 == PRE_P3) begin : g_bad_pre
    $error("prebyte codes must differ");
  end

  // Mode from the opcode columns
  function automatic cafa_mode_t mode_of(input logic [7:0] opc);
    logic [3:0] hi;
    hi = opc[7:4];
    if (opc == 8'h12 || opc == 8'h13) mode_of = M_DIR;
    else if (opc == 8'h1E || opc == 8'h1F) mode_of = M_IND;
    else if (hi == 4'h2) mode_of = M_REL;
    else if (hi == 4'h6) mode_of = M_IND;
    else if (hi == 4'h7) mode_of = M_EXT;
    else if (hi[3] && hi[1:0] == 2'b00) mode_of = M_IMM;
    else if (hi[3] && hi[1:0] == 2'b01) mode_of = M_DIR;
    else if (hi[3] && hi[1:0] == 2'b10) mode_of = M_IND;
    else if (hi[3]) mode_of = M_EXT;
    else mode_of = M_INH;
  endfunction

  // Operand byte count for an opcode
  function automatic logic [1:0] count_of(input logic [7:0] opc, input cafa_mode_t md);
    logic wide;
    wide = (opc[3:0] == 4'h3) || (opc[3:0] == 4'hC) || (opc[3:0] == 4'hE);
    if (md == M_INH) count_of = 2'd0;
    else if (opc[7:4] == 4'h1) count_of = 2'd3;
    else if (md == M_EXT) count_of = 2'd2;
    else if (md == M_IMM && wide) count_of = 2'd2;
    else count_of = 2'd1;
  endfunction

  // Prebyte recognition: hit bit and page
  function automatic logic [2:0] page_of(input logic [7:0] b);
    if (b == PRE_P1) page_of = 3'b101;
    else if (b == PRE_P2) page_of = 3'b110;
    else if (b == PRE_P3) page_of = 3'b111;
    else page_of = 3'b000;
  endfunction

  typedef struct packed {
    cafa_fsm_t state;
    logic run;
    logic halt_req;
    logic [15:0] pc;
    logic [15:0] xidx;
    logic [15:0] yidx;
    logic [15:0] imm_addr;
    logic [1:0] page;
    logic pre_seen;
    logic [7:0] opcode;
    cafa_mode_t mode;
    logic [1:0] cnt;
    logic [1:0] left;
    logic [2:0] len;
    logic [7:0] first;
    logic [23:0] opnd;
    logic [7:0] rdata;
    logic done;
    logic [1:0] o_page;
    logic [7:0] o_opc;
    cafa_mode_t o_mode;
    logic [2:0] o_len;
    logic [23:0] o_opnd;
    logic [15:0] ea;
    logic ea_valid;
  } cafa_core_st_t;

  cafa_core_st_t cur;
  cafa_core_st_t next_st;
  logic [2:0] pg;
  logic idx_zero;
  logic stop_halt;
  logic [15:0] ea_w;
  logic ea_ok;

  // Effective address of the instruction just fetched
  cafa_ea u_ea (
    .mode(cur.mode),
    .use_y(cur.page[0]),
    .first(cur.first),
    .opnd(cur.opnd[15:0]),
    .xidx(cur.xidx),
    .yidx(cur.yidx),
    .imm_addr(cur.imm_addr),
    .next_pc(cur.pc),
    .ea(ea_w),
    .ea_valid(ea_ok)
  );

  // Condition flags and interrupt masks
  cafa_flags u_flags (
    .mclk(mclk),
    .rst(rst),
    .op_valid(op_valid),
    .op_kind(op_kind),
    .op_a(op_a),
    .op_b(op_b),
    .carry_in(carry_in),
    .idx_zero(idx_zero),
    .irq_req(irq_req),
    .hpri_req(high_priority_int_pin),
    .irq_stacked(irq_stacked),
    .hpri_stacked(hpri_stacked),
    .irq_grant(irq_grant),
    .hpri_grant(hpri_grant),
    .flags(condition_flags_reg),
    .result(alu_result),
    .stop_halt(stop_halt)
  );

  // Register port, index steps and fetch sequencer
  always_comb begin
    next_st = cur;
    next_st.done = 1'b0;
    next_st.rdata = 8'h00;
    idx_zero = 1'b0;
    pg = page_of(mem_rdata);
    // Software writes
    if (reg_wr) begin
      if (reg_addr == `CAFA_R_IXH) next_st.xidx[15:8] = reg_wdata;
      else if (reg_addr == `CAFA_R_IXL) next_st.xidx[7:0] = reg_wdata;
      else if (reg_addr == `CAFA_R_IYH) next_st.yidx[15:8] = reg_wdata;
      else if (reg_addr == `CAFA_R_IYL) next_st.yidx[7:0] = reg_wdata;
      else if (reg_addr == `CAFA_R_PCH && cur.state == S_IDLE) next_st.pc[15:8] = reg_wdata;
      else if (reg_addr == `CAFA_R_PCL && cur.state == S_IDLE) next_st.pc[7:0] = reg_wdata;
      else if (reg_addr == `CAFA_R_CTRL) next_st.run = reg_wdata[`CAFA_CTRL_RUN];
    end
    // Software reads, data in the next cycle
    if (reg_rd) begin
      if (reg_addr == `CAFA_R_FLAGS) next_st.rdata = condition_flags_reg;
      else if (reg_addr == `CAFA_R_IXH) next_st.rdata = cur.xidx[15:8];
      else if (reg_addr == `CAFA_R_IXL) next_st.rdata = cur.xidx[7:0];
      else if (reg_addr == `CAFA_R_IYH) next_st.rdata = cur.yidx[15:8];
      else if (reg_addr == `CAFA_R_IYL) next_st.rdata = cur.yidx[7:0];
      else if (reg_addr == `CAFA_R_PCH) next_st.rdata = cur.pc[15:8];
      else if (reg_addr == `CAFA_R_PCL) next_st.rdata = cur.pc[7:0];
      else if (reg_addr == `CAFA_R_CTRL) next_st.rdata = {7'h00, cur.run};
      else if (reg_addr == `CAFA_R_EAH) next_st.rdata = cur.ea[15:8];
      else if (reg_addr == `CAFA_R_EAL) next_st.rdata = cur.ea[7:0];
      else if (reg_addr == `CAFA_R_OPC) next_st.rdata = cur.o_opc;
      else if (reg_addr == `CAFA_R_INFO) next_st.rdata = {cur.o_page, cur.o_mode, cur.o_len};
      else if (reg_addr == `CAFA_R_RES) next_st.rdata = alu_result;
    end
    // Index increment and decrement, zero seen by the flags
    if (op_valid) begin
      case (op_kind)
        K_XINC: next_st.xidx = cur.xidx + 16'h0001;
        K_XDEC: next_st.xidx = cur.xidx - 16'h0001;
        K_YINC: next_st.yidx = cur.yidx + 16'h0001;
        K_YDEC: next_st.yidx = cur.yidx - 16'h0001;
        default: ;
      endcase
      if (op_kind inside {K_XINC, K_XDEC}) idx_zero = (next_st.xidx == 16'h0000);
      if (op_kind inside {K_YINC, K_YDEC}) idx_zero = (next_st.yidx == 16'h0000);
    end
    // A halt is taken only at an instruction boundary
    if (stop_halt) next_st.halt_req = 1'b1;
    case (cur.state)
      S_IDLE: begin
        if (cur.halt_req || stop_halt) begin
          next_st.halt_req = 1'b0;
          next_st.state = S_HALT;
        end else if (cur.run) begin
          next_st.state = S_REQ;
        end
      end
      S_REQ: begin
        next_st.pc = cur.pc + 16'h0001;
        next_st.state = S_TAKE;
      end
      S_TAKE: begin
        next_st.len = cur.len + 3'd1;
        next_st.state = S_REQ;
        if (cur.left != 2'd0) begin
          // Operand bytes shift in, earlier byte more significant
          next_st.opnd = {cur.opnd[15:0], mem_rdata};
          if (cur.left == cur.cnt) next_st.first = mem_rdata;
          next_st.left = cur.left - 2'd1;
          if (cur.left == 2'd1) next_st.state = S_DONE;
        end else if (pg[2] && !cur.pre_seen) begin
          next_st.pre_seen = 1'b1;
          next_st.page = pg[1:0];
        end else begin
          next_st.opcode = mem_rdata;
          next_st.mode = mode_of(mem_rdata);
          next_st.cnt = count_of(mem_rdata, next_st.mode);
          next_st.left = next_st.cnt;
          next_st.imm_addr = cur.pc;
          next_st.opnd = 24'h00_0000;
          next_st.first = 8'h00;
          if (next_st.cnt == 2'd0) next_st.state = S_DONE;
        end
      end
      S_DONE: begin
        next_st.done = 1'b1;
        next_st.o_page = cur.page;
        next_st.o_opc = cur.opcode;
        next_st.o_mode = cur.mode;
        next_st.o_len = cur.len;
        next_st.o_opnd = cur.opnd;
        next_st.ea = ea_ok ? ea_w : 16'h0000;
        next_st.ea_valid = ea_ok;
        if (cur.mode == M_REL && branch_true) next_st.pc = ea_w;
        next_st.page = 2'd0;
        next_st.pre_seen = 1'b0;
        next_st.len = 3'd0;
        if (cur.halt_req || stop_halt) begin
          next_st.halt_req = 1'b0;
          next_st.state = S_HALT;
        end else begin
          next_st.state = cur.run ? S_REQ : S_IDLE;
        end
      end
      S_HALT: begin
        // Any interrupt request wakes the fetcher
        if (irq_req || high_priority_int_pin) next_st.state = S_IDLE;
      end
      default: next_st.state = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_st;
    end
  end

  // Outputs
  assign reg_rdata = cur.rdata;
  assign mem_addr = cur.pc;
  assign mem_rd = (cur.state == S_REQ);
  assign low_power = (cur.state == S_HALT);
  assign instr_done = cur.done;
  assign instr_page = cur.o_page;
  assign instr_opcode = cur.o_opc;
  assign instr_mode = cur.o_mode;
  assign instr_len = cur.o_len;
  assign instr_operand = cur.o_opnd;
  assign instr_ea = cur.ea;
  assign instr_ea_valid = cur.ea_valid;

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_len_range: assert property (instr_done |-> instr_len >= 3'd1 && instr_len <= 3'd5)
    else $error("instruction length out of range");
  a_page_select: assert property (cur.state == S_TAKE && cur.left == 2'd0 && !cur.pre_seen
    && mem_rdata == PRE_P2 |=> cur.page == 2'd2 && cur.pre_seen && mem_rd)
    else $error("prebyte did not select page");
  a_direct_page: assert property (instr_done && instr_mode == M_DIR |-> instr_ea[15:8] == 8'h00)
    else $error("direct address high byte not zero");
  a_ext_word: assert property (instr_done && instr_mode == M_EXT |-> instr_ea == instr_operand[15:0])
    else $error("extended address mismatch");
  a_inh_no_ea: assert property (instr_done && instr_mode == M_INH |-> !instr_ea_valid)
    else $error("inherent mode produced an address");
  a_stop_nop: assert property (op_valid && op_kind == K_STOP && condition_flags_reg[`CAFA_F_S]
    && !low_power && !cur.halt_req |=> !low_power [*2])
    else $error("disabled halt stopped the fetcher");
  a_branch_take: assert property (cur.state == S_DONE && cur.mode == M_REL && branch_true
    |=> mem_addr == $past(ea_w))
    else $error("taken branch target not loaded");

  c_prebyte: cover property (instr_done && instr_page != 2'd0);
  c_extended: cover property (instr_done && instr_mode == M_EXT);
  c_branch: cover property (cur.state == S_DONE && cur.mode == M_REL && branch_true);
  c_halt: cover property (low_power ##1 !low_power);
endmodule

// >>> dv/cafa_mem.sv
// Program and data memory model on the fetch port of the flags and addressing block
// Assumes a read strobe one cycle long; the byte stands only in the cycle after it
module cafa_mem (
  // Clock
  input wire logic mclk,
  // Fetch port
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  // Unused bytes read as a one-byte inherent opcode
  initial begin
    foreach (mem[i]) mem[i] = 8'h01;
    mem_rdata = 8'h00;
  end
  // Byte only in the cycle after the strobe, inverted junk otherwise
  always @(posedge mclk) begin
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
  end
endmodule

// >>> dv/tb.sv
// Self-checking bench for the flags and addressing core
// Assumes the core package and the memory model are compiled first
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cafa_pkg::*;
  typedef struct {
    logic [1:0] pg;
    logic [7:0] opc;
    cafa_mode_t m;
    logic [2:0] n;
    logic [23:0] opd;
    logic [15:0] ea;
  } cafa_exp_t;
  logic mclk, rst, reg_wr, reg_rd, mem_rd, instr_done, instr_ea_valid, branch_true, op_valid, carry_in;
  logic irq_req, high_priority_int_pin, irq_stacked, hpri_stacked, irq_grant, hpri_grant, low_power;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, mem_rdata, instr_opcode, op_a, op_b, alu_result, condition_flags_reg, ef, er;
  logic [15:0] mem_addr, instr_ea, xidx, yidx, p;
  logic [1:0] instr_page;
  logic [2:0] instr_len;
  logic [23:0] instr_operand;
  cafa_mode_t instr_mode;
  cafa_op_t op_kind;
  cafa_op_t kinds [6] = '{K_ADD, K_ADC, K_SUMBA, K_SUB, K_CMP, K_AND};
  cafa_op_t steps [5] = '{K_XINC, K_XDEC, K_YINC, K_YDEC, K_XDEC};
  int fail_count, compares, cyc;
  cafa_exp_t q[$];

  cafa_core u_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .instr_done(instr_done), .instr_page(instr_page), .instr_opcode(instr_opcode), .instr_mode(instr_mode),
    .instr_len(instr_len), .instr_operand(instr_operand), .instr_ea(instr_ea), .instr_ea_valid(instr_ea_valid),
    .branch_true(branch_true), .op_valid(op_valid), .op_kind(op_kind), .op_a(op_a), .op_b(op_b),
    .carry_in(carry_in), .alu_result(alu_result), .condition_flags_reg(condition_flags_reg), .irq_req(irq_req),
    .high_priority_int_pin(high_priority_int_pin), .irq_stacked(irq_stacked), .hpri_stacked(hpri_stacked),
    .irq_grant(irq_grant), .hpri_grant(hpri_grant), .low_power(low_power));
  cafa_mem u_mem (.mclk(mclk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));

  // Clock and hang guard
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (fail_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] s, input logic [23:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Register port cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, reg_rdata, e);
  endtask

  // One operation pulse, then the expected flags and result
  task automatic op(input cafa_op_t k, input logic [7:0] a, input logic [7:0] b, input logic c);
    logic [8:0] s;
    @(posedge mclk);
    op_valid <= 1'b1;
    op_kind <= k;
    op_a <= a;
    op_b <= b;
    carry_in <= c;
    @(posedge mclk);
    op_valid <= 1'b0;
    s = 9'h000;
    case (k)
      K_ADD, K_SUMBA, K_ADC: begin
        s = a + b + ((k == K_ADC) ? c : 1'b0);
        ef[5] = s[4] ^ a[4] ^ b[4];
      end
      K_SUB, K_CMP: s = a - b;
      K_AND: s = {1'b0, a & b};
      K_XINC: xidx = xidx + 16'h0001;
      K_XDEC: xidx = xidx - 16'h0001;
      K_YINC: yidx = yidx + 16'h0001;
      K_YDEC: yidx = yidx - 16'h0001;
      K_TAP, K_RETI: ef = {a[7], ef[6] & a[6], a[5:0]};
      default: ef = ef;
    endcase
    if (k inside {K_ADD, K_ADC, K_SUMBA, K_SUB, K_CMP, K_AND}) begin
      ef[3] = s[7];
      ef[2] = (s[7:0] == 8'h00);
      if (k != K_CMP) er = s[7:0];
    end
    if (k inside {K_XINC, K_XDEC}) ef[2] = (xidx == 16'h0000);
    if (k inside {K_YINC, K_YDEC}) ef[2] = (yidx == 16'h0000);
    #1;
    chk("flags", condition_flags_reg, ef);
    chk("result", alu_result, er);
  endtask

  // Place one instruction in memory and queue what the decoder must show
  task automatic ins(input logic [39:0] b, input logic [2:0] n, input logic [1:0] pg, input cafa_mode_t m,
    input logic [15:0] ea);
    cafa_exp_t e;
    int k;
    k = (pg != 2'b00) ? 2 : 1;
    e.pg = pg;
    e.m = m;
    e.n = n;
    e.ea = ea;
    e.opc = b[8*(n-k) +: 8];
    e.opd = 24'(b & ((40'h1 << (8 * (n - k))) - 40'h1));
    for (int i = n - 1; i >= 0; i--) begin
      u_mem.mem[p] = b[8*i +: 8];
      p = p + 16'h0001;
    end
    q.push_back(e);
  endtask

  // Main sequence
  initial begin
    {mclk, reg_wr, reg_rd, op_valid, carry_in, irq_stacked, hpri_stacked} = '0;
    {rst, branch_true, irq_req, high_priority_int_pin} = 4'b1011;
    {reg_addr, reg_wdata, op_a, op_b, er, fail_count, compares, cyc} = '0;
    op_kind = K_NONE;
    ef = 8'hD0;
    void'($urandom(32'h7708));
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk("flags", condition_flags_reg, ef);
    chk("grants", {irq_grant, hpri_grant}, 2'b00);
    @(posedge mclk);
    irq_req <= 1'b0;
    high_priority_int_pin <= 1'b0;
    rd(4'hD, 8'h00, "unmapped");
    rd(4'h0, 8'hD0, "flags_reg");
    // Arithmetic and logic: corners first, then random
    for (int i = 0; i < 40; i++) begin
      case (i)
        0: op(K_ADD, 8'h08, 8'h08, 1'b0);
        1: op(K_ADC, 8'hF7, 8'h08, 1'b1);
        2: op(K_SUMBA, 8'h80, 8'h00, 1'b0);
        3: op(K_CMP, 8'h55, 8'h55, 1'b0);
        default: op(kinds[$urandom_range(5)], 8'($urandom), 8'($urandom), 1'($urandom));
      endcase
    end
    // Index steps through zero
    xidx = 16'hFFFF;
    yidx = 16'hFFFF;
    for (int i = 1; i < 5; i++) wr(4'(i), 8'hFF);
    foreach (steps[i]) op(steps[i], 8'h00, 8'h00, 1'b0);
    rd(4'h1, xidx[15:8], "xidx_hi");
    rd(4'h2, xidx[7:0], "xidx_lo");
    rd(4'h4, yidx[7:0], "yidx_lo");
    rd(4'hC, er, "res_reg");
    // Halt while stop is disabled
    op(K_STOP, 8'h00, 8'h00, 1'b0);
    repeat (4) @(posedge mclk);
    #1;
    chk("low_power", low_power, 1'b0);
    // Software clears the masks; the high mask cannot be set back
    op(K_TAP, 8'h00, 8'h00, 1'b0);
    op(K_RETI, 8'h40, 8'h00, 1'b0);
    // Maskable then high priority acknowledge
    @(posedge mclk);
    irq_req <= 1'b1;
    irq_stacked <= 1'b1;
    #1;
    chk("irq_grant", irq_grant, 1'b1);
    @(posedge mclk);
    irq_stacked <= 1'b0;
    high_priority_int_pin <= 1'b1;
    #1;
    ef[4] = 1'b1;
    chk("irq_ack", {irq_grant, hpri_grant, condition_flags_reg}, {2'b01, ef});
    @(posedge mclk);
    hpri_stacked <= 1'b1;
    irq_req <= 1'b0;
    @(posedge mclk);
    hpri_stacked <= 1'b0;
    #1;
    ef[6] = 1'b1;
    chk("hpri_ack", {hpri_grant, condition_flags_reg}, {1'b0, ef});
    @(posedge mclk);
    high_priority_int_pin <= 1'b0;
    // Fetch and decode from an odd start address
    wr(4'h1, 8'h12);
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h34);
    wr(4'h4, 8'h00);
    wr(4'h5, 8'h03);
    wr(4'h6, 8'h01);
    p = 16'h0301;
    ins(40'hB61234, 3, 0, M_EXT, 16'h1234);
    ins(40'h965A, 2, 0, M_DIR, 16'h005A);
    ins(40'h8CABCD, 3, 0, M_IMM, 16'h0000);
    ins(40'h8677, 2, 0, M_IMM, 16'h0000);
    ins(40'h01, 1, 0, M_INH, 16'h0000);
    ins(40'h1808, 2, 1, M_INH, 16'h0000);
    ins(40'h1AA6FF, 3, 2, M_IND, 16'h12FF);
    ins(40'hCDEE80, 3, 3, M_IND, 16'h3480);
    ins(40'h18E610, 3, 1, M_IND, 16'h3410);
    ins(40'h1A1E102233, 5, 2, M_IND, 16'h1210);
    ins(40'h2005, 2, 0, M_REL, p + 16'h0007);
    ins(40'h20F0, 2, 0, M_REL, p - 16'h000E);
    wr(4'h7, 8'h01);
    foreach (q[i]) begin
      for (int w = 0; w < 40 && instr_done !== 1'b1; w++) begin
        @(posedge mclk);
        #1;
      end
      chk("done", instr_done, 1'b1);
      chk("page", instr_page, q[i].pg);
      chk("opcode", instr_opcode, q[i].opc);
      chk("len", instr_len, q[i].n);
      chk("operand", instr_operand, q[i].opd);
      chk("mode", instr_mode, q[i].m);
      chk("ea_valid", instr_ea_valid, q[i].m != M_INH);
      if (q[i].m != M_IMM) chk("ea", instr_ea, q[i].ea);
      @(posedge mclk);
      // Only the last branch is taken, so the earlier one falls through
      branch_true <= (i == q.size() - 2);
      #1;
    end
    wr(4'h7, 8'h00);
    // Reset in mid-run restores both masks and stop disable
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk("flags_rerst", condition_flags_reg, 8'hD0);
    stop_test();
  end
endmodule
